// file: hw/sdr_pkg.sv
// Package with the constants of the step/direction status response block.
// Assumes a single 100 MHz system clock domain and no register bus.
package sdr_pkg;

    // ------------------------------------------------------------------
    // Widths and response field positions
    // ------------------------------------------------------------------
    localparam int RESP_W = 20;          // Response word width.
    localparam int POS_W = 10;           // Microstep counter width.
    localparam int LOAD_W = 10;          // Load measurement width.
    localparam int SCALE_W = 5;          // Current scaling width.
    localparam int VAL_LSB = 10;         // Lowest bit of the value field.
    localparam int BIT_STANDSTILL = 7;   // Standstill flag position.
    localparam int BIT_OL_B = 6;         // Open load coil B position.
    localparam int BIT_OL_A = 5;         // Open load coil A position.
    localparam int BIT_S2G_B = 4;        // Short coil B position.
    localparam int BIT_S2G_A = 3;        // Short coil A position.
    localparam int BIT_OT_WARN = 2;      // Overtemperature warning position.
    localparam int BIT_OT_SHUT = 1;      // Overtemperature shutdown position.
    localparam int BIT_STALL = 0;        // Stall flag position.

    // ------------------------------------------------------------------
    // Read select encodings
    // ------------------------------------------------------------------
    localparam logic [1:0] SEL_POSITION = 2'h0;
    localparam logic [1:0] SEL_LOAD = 2'h1;
    localparam logic [1:0] SEL_LOAD_SCALE = 2'h2;

    // ------------------------------------------------------------------
    // Counts and reset values
    // ------------------------------------------------------------------
    localparam int STANDSTILL_EXP = 20;  // Standstill window is 2 to this power.
    localparam int STANDSTILL_CYCLES = 1 << STANDSTILL_EXP;
    localparam logic [1:0] SHORT_LIMIT = 2'h3;    // Shutdown count of shorts.
    localparam logic [POS_W-1:0] POS_RESET = 10'h000;
    localparam logic [20:0] IDLE_RESET = 21'h000000;

endpackage : sdr_pkg

// file: hw/sdr_short_guard.sv
// Per coil short-to-ground counter with latched shutdown.
// Assumes short and polarity events are single cycle pulses on mclk_i.
`timescale 1ns/1ps
module sdr_short_guard
    import sdr_pkg::*;
(
    // Clock and reset.
    input wire logic mclk_i,
    input wire logic reset_n_i,
    input wire logic clk_en_i,
    // Events and clearing.
    input wire logic short_det_i,
    input wire logic polarity_chg_i,
    input wire logic clear_i,
    // Status.
    output logic shutdown_o,
    output logic suspend_o
);

    // ------------------------------------------------------------------
    // Counter
    // ------------------------------------------------------------------
    logic [1:0] count_r;   // Shorts seen minus polarity changes.
    logic [1:0] count_nxt; // Next counter value.
    logic shut_r;          // Latched shutdown.
    logic hit_limit;       // Counter reaches the limit this cycle.

    // Increment wins over a simultaneous decrement so no short is lost.
    assign count_nxt = clear_i ? 2'h0 :
                       (short_det_i && count_r != SHORT_LIMIT) ? count_r + 2'h1 : // R11
                       (polarity_chg_i && !short_det_i && count_r != 2'h0) ?
                       count_r - 2'h1 : count_r; // R12
    assign hit_limit = (count_nxt == SHORT_LIMIT);
    assign suspend_o = short_det_i; // R11
    assign shutdown_o = shut_r;

    // Shutdown holds until the driver is disabled or off time is zero.
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            count_r <= 2'h0;
            shut_r <= 1'b0;
        end else if (clk_en_i) begin
            count_r <= count_nxt;
            shut_r <= clear_i ? 1'b0 : (shut_r | hit_limit); // R12 R13
        end
    end

endmodule : sdr_short_guard

// file: hw/sdr_status_top.sv
// Step/direction front end with a serial status response word.
// Assumes all inputs except step and direction are synchronous to mclk_i; analog events arrive as pulses.
//
// Overview of operation
// R01 - Return 20-bit status on every write
// R02 - Read select picks response value format
// R03 - Select 0: bits 19..10 microstep position
// R04 - Top position bit is coil A polarity
// R05 - Select 1 load; select 2 load/scale
// R06 - Controller ignores reserved bits 9 and 8
// R07 - Standstill after 2^20 cycles without steps
// R08 - Open load set without chopper, cleared by current
// R09 - Open load only reported, no action
// R10 - Controller checks open load in slow motion
// R11 - Short increments counter, suspends chopper, reports
// R12 - Polarity change decrements; shutdown at three
// R13 - Shutdown cleared by disable or zero off-time
// R14 - Report overtemperature warning and shutdown
// R15 - Stall flag also drives stall test output
// R16 - Double edge makes both step edges active
// R17 - Synchronise step and direction before edges
// R18 - Step adds or subtracts step size by direction
// R19 - Controller never programs read select three
// R20 - Capture word at frame start, shift out
`timescale 1ns/1ps
module sdr_status_top
    import sdr_pkg::*;
(
    // Clock, reset and clock enable.
    input wire logic mclk_i,
    input wire logic reset_n_i,
    input wire logic clk_en_i,
    // Step and direction from the motion controller.
    input wire logic step_i,
    input wire logic dir_i,
    input wire logic [POS_W-1:0] step_size_i,
    // Configuration taken from the control and config words.
    input wire logic double_edge_select_i,
    input wire logic [1:0] read_select_i,
    input wire logic driver_enable_n_i,
    input wire logic off_time_zero_i,
    // Analog front end events and levels.
    input wire logic [LOAD_W-1:0] load_value_i,
    input wire logic [SCALE_W-1:0] current_scale_value_i,
    input wire logic chopper_event_a_i,
    input wire logic chopper_event_b_i,
    input wire logic current_above_a_i,
    input wire logic current_above_b_i,
    input wire logic polarity_chg_a_i,
    input wire logic polarity_chg_b_i,
    input wire logic short_det_a_i,
    input wire logic short_det_b_i,
    input wire logic overtemp_warning_i,
    input wire logic overtemp_shutdown_i,
    input wire logic stall_flag_i,
    // Serial response frame.
    input wire logic frame_start_i,
    input wire logic shift_i,
    output logic resp_bit_o,
    // Driver and status outputs.
    output logic [POS_W-1:0] microstep_position_o,
    output logic [RESP_W-1:0] driver_status_word_o,
    output logic chopper_suspend_a_o,
    output logic chopper_suspend_b_o,
    output logic bridge_off_o,
    output logic stall_test_output_o
);

    // ------------------------------------------------------------------
    // Step and direction synchronisers
    // ------------------------------------------------------------------
    logic step_s1_r, step_s2_r, step_d_r; // Step sync stages and delayed copy.
    logic dir_s1_r, dir_s2_r;             // Direction sync stages.

    // Two flip-flop synchronisers; only the second stage is used further.
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            step_s1_r <= 1'b0;
            step_s2_r <= 1'b0;
            step_d_r <= 1'b0;
            dir_s1_r <= 1'b0;
            dir_s2_r <= 1'b0;
        end else if (clk_en_i) begin
            step_s1_r <= step_i; // R17
            step_s2_r <= step_s1_r;
            step_d_r <= step_s2_r;
            dir_s1_r <= dir_i;
            dir_s2_r <= dir_s1_r;
        end
    end

    // ------------------------------------------------------------------
    // Active edge and microstep counter
    // ------------------------------------------------------------------
    logic rise_edge;   // Synchronised rising step edge.
    logic fall_edge;   // Synchronised falling step edge.
    logic step_active; // Active edge for this cycle.
    logic [POS_W-1:0] pos_r;   // Microstep counter.
    logic [POS_W-1:0] pos_nxt; // Next microstep counter.

    assign rise_edge = step_s2_r & ~step_d_r;
    assign fall_edge = ~step_s2_r & step_d_r;
    assign step_active = rise_edge | (double_edge_select_i & fall_edge); // R16
    assign pos_nxt = !step_active ? pos_r :
                     dir_s2_r ? pos_r - step_size_i : pos_r + step_size_i; // R18
    assign microstep_position_o = pos_r;

    // Counter wraps naturally over the full electrical turn.
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            pos_r <= POS_RESET;
        end else if (clk_en_i) begin
            pos_r <= pos_nxt;
        end
    end

    // ------------------------------------------------------------------
    // Standstill detection
    // ------------------------------------------------------------------
    logic [STANDSTILL_EXP:0] idle_r; // Cycles since last active edge, saturating.
    logic standstill;                // Window elapsed without an active edge.

    assign standstill = idle_r[STANDSTILL_EXP]; // R07

    // Saturates once the top bit sets, so the flag stays until the next edge.
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            idle_r <= IDLE_RESET;
        end else if (clk_en_i) begin
            if (step_active) begin
                idle_r <= IDLE_RESET; // R07
            end else if (!standstill) begin
                idle_r <= idle_r + 21'h000001;
            end
        end
    end

    // ------------------------------------------------------------------
    // Open load flags, one per coil
    // ------------------------------------------------------------------
    logic [1:0] chop_seen_r; // Chopper event seen in the current polarity period.
    logic [1:0] open_load_r; // Open load flags, index 0 coil A, 1 coil B.
    logic [1:0] chop_ev;
    logic [1:0] pol_chg;
    logic [1:0] cur_above;

    assign chop_ev = {chopper_event_b_i, chopper_event_a_i};
    assign pol_chg = {polarity_chg_b_i, polarity_chg_a_i};
    assign cur_above = {current_above_b_i, current_above_a_i};

    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_open_load
            // Flags are reported only; nothing in the bridge reacts to them.
            always_ff @(posedge mclk_i or negedge reset_n_i) begin
                if (!reset_n_i) begin
                    chop_seen_r[gi] <= 1'b0;
                    open_load_r[gi] <= 1'b0;
                end else if (clk_en_i) begin
                    if (pol_chg[gi]) begin
                        chop_seen_r[gi] <= 1'b0;
                        if (!chop_seen_r[gi] && !chop_ev[gi]) begin
                            open_load_r[gi] <= 1'b1; // R08 R09
                        end else if (cur_above[gi]) begin
                            open_load_r[gi] <= 1'b0;
                        end
                    end else begin
                        chop_seen_r[gi] <= chop_seen_r[gi] | chop_ev[gi];
                        if (cur_above[gi]) begin
                            open_load_r[gi] <= 1'b0; // R08
                        end
                    end
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------------
    // Short to ground protection
    // ------------------------------------------------------------------
    logic short_clear; // Driver disabled or off time zero.
    logic shut_a, shut_b;

    assign short_clear = driver_enable_n_i | off_time_zero_i; // R13

    sdr_short_guard u_guard_a (
        .mclk_i(mclk_i),
        .reset_n_i(reset_n_i),
        .clk_en_i(clk_en_i),
        .short_det_i(short_det_a_i),
        .polarity_chg_i(polarity_chg_a_i),
        .clear_i(short_clear),
        .shutdown_o(shut_a),
        .suspend_o(chopper_suspend_a_o)
    );

    sdr_short_guard u_guard_b (
        .mclk_i(mclk_i),
        .reset_n_i(reset_n_i),
        .clk_en_i(clk_en_i),
        .short_det_i(short_det_b_i),
        .polarity_chg_i(polarity_chg_b_i),
        .clear_i(short_clear),
        .shutdown_o(shut_b),
        .suspend_o(chopper_suspend_b_o)
    );

    assign bridge_off_o = shut_a | shut_b; // R12

    // ------------------------------------------------------------------
    // Response word assembly and serial shifter
    // ------------------------------------------------------------------
    logic [9:0] value_field;          // Selected upper field.
    logic [RESP_W-1:0] status_live;   // Word as it stands this cycle.
    logic [RESP_W-1:0] status_r;      // Word captured at frame start.
    logic [RESP_W-1:0] shift_r;       // Serial shift register.

    // Select three is reserved; it reads back as zero.
    assign value_field = (read_select_i == SEL_POSITION) ? pos_r :            // R03 R04
                         (read_select_i == SEL_LOAD) ? load_value_i :         // R05
                         (read_select_i == SEL_LOAD_SCALE) ?
                         {load_value_i[LOAD_W-1 -: 5], current_scale_value_i} : // R05
                         10'h000; // R02
    assign status_live = {value_field, 2'h0, standstill, open_load_r[1], open_load_r[0],
                          shut_b, shut_a, overtemp_warning_i, overtemp_shutdown_i,
                          stall_flag_i}; // R11 R14 R15
    assign driver_status_word_o = status_r;
    assign resp_bit_o = shift_r[RESP_W-1];
    assign stall_test_output_o = stall_flag_i; // R15

    // Capture at frame start, then shift MSB first on each shift strobe.
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            status_r <= 20'h00000;
            shift_r <= 20'h00000;
        end else if (clk_en_i) begin
            if (frame_start_i) begin
                status_r <= status_live; // R01 R20
                shift_r <= status_live;
            end else if (shift_i) begin
                shift_r <= {shift_r[RESP_W-2:0], 1'b0}; // R20
            end
        end
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!reset_n_i);

    step_up_a: assert property (clk_en_i && step_active && !dir_s2_r |=> // R18
        pos_r == $past(pos_r) + $past(step_size_i)) else $error("step up wrong");
    step_down_a: assert property (clk_en_i && step_active && dir_s2_r |=> // R18
        pos_r == $past(pos_r) - $past(step_size_i)) else $error("step down wrong");
    single_edge_a: assert property (clk_en_i && !double_edge_select_i && fall_edge // R16
        |=> pos_r == $past(pos_r)) else $error("falling edge counted");
    sync_delay_a: assert property (clk_en_i && step_i ##1 clk_en_i && step_i // R17
        |=> step_s2_r) else $error("step sync late");
    frame_capture_a: assert property (clk_en_i && frame_start_i |=> // R01
        driver_status_word_o == $past(status_live)) else $error("capture wrong");
    pos_field_a: assert property (read_select_i == SEL_POSITION |-> // R03
        status_live[RESP_W-1:VAL_LSB] == pos_r) else $error("position field wrong");
    scale_field_a: assert property (read_select_i == SEL_LOAD_SCALE |-> // R05
        status_live[14:10] == current_scale_value_i) else $error("scale field wrong");
    standstill_clr_a: assert property (clk_en_i && step_active |=> // R07
        !status_live[BIT_STANDSTILL]) else $error("standstill not cleared");
    stall_pin_a: assert property (status_live[BIT_STALL] == stall_test_output_o) // R15
        else $error("stall pin mismatch");
    shut_clear_a: assert property (short_clear && clk_en_i |=> !bridge_off_o) // R13
        else $error("shutdown not cleared");

    step_cov_c: cover property (clk_en_i && step_active);
    frame_cov_c: cover property (clk_en_i && frame_start_i ##1 shift_i [*3]);
    shut_cov_c: cover property (bridge_off_o);

endmodule : sdr_status_top

// file: sim/sdr_ctl_model.sv
// Motion controller model: strobes a serial frame and reads the response back.
// Assumes the block answers one bit per shift strobe, most significant bit first.
`timescale 1ns/1ps
module sdr_ctl_model
    import sdr_pkg::*;
(
    // Clock and reset.
    input wire logic mclk_i,
    input wire logic reset_n_i,
    // Bench request and serial data.
    input wire logic frame_go_i,
    input wire logic resp_bit_i,
    // Frame strobes and the collected word.
    output logic frame_start_o,
    output logic shift_o,
    output logic [RESP_W-1:0] frame_word_o,
    output logic frame_done_o
);
    logic [4:0] cnt_r; // Frame phase, zero when idle.

    // -----------------------------------------------------------------
    // Frame sequencer
    // -----------------------------------------------------------------
    // Start, then 19 shifts, sampling 20 bits one edge after each change.
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            cnt_r <= 5'h00;
            frame_start_o <= 1'b0;
            shift_o <= 1'b0;
            frame_word_o <= '0;
            frame_done_o <= 1'b0;
        end else begin
            frame_start_o <= frame_go_i && (cnt_r == 5'h00);
            shift_o <= (cnt_r != 5'h00) && (cnt_r < 5'h14);
            frame_done_o <= (cnt_r == 5'h15);
            if (cnt_r >= 5'h02) begin
                frame_word_o <= {frame_word_o[RESP_W-2:0], resp_bit_i};
            end
            if (cnt_r == 5'h00) begin
                cnt_r <= {4'h0, frame_go_i};
            end else begin
                cnt_r <= (cnt_r == 5'h15) ? 5'h00 : cnt_r + 5'h01;
            end
        end
    end
endmodule : sdr_ctl_model

// file: sim/sdr_status_top_bench.sv
// Self-checking bench for the status response block.
// Assumes the controller model in sdr_ctl_model and a 100 MHz clock.
`timescale 1ns/1ps
module sdr_status_top_bench;
    import sdr_pkg::*;
    // Design inputs, all given a value at time zero.
    logic mclk_i = 1'b0, reset_n_i = 1'b0, step_i = 1'b0, dir_i = 1'b0;
    logic [POS_W-1:0] step_size_i = 10'h010, load_value_i = 10'h2A5;
    logic [SCALE_W-1:0] current_scale_value_i = 5'h13;
    logic double_edge_select_i = 1'b0, driver_enable_n_i = 1'b0, off_time_zero_i = 1'b0;
    logic [1:0] read_select_i = 2'h0;
    logic chopper_event_a_i = 1'b0, chopper_event_b_i = 1'b0;
    logic current_above_a_i = 1'b0, current_above_b_i = 1'b0;
    logic polarity_chg_a_i = 1'b0, polarity_chg_b_i = 1'b0;
    logic short_det_a_i = 1'b0, short_det_b_i = 1'b0;
    logic overtemp_warning_i = 1'b0, overtemp_shutdown_i = 1'b0, stall_flag_i = 1'b0;
    // Frame strobes, outputs and the model's word.
    logic frame_start_i, shift_i, resp_bit_o, frame_go = 1'b0, frame_done;
    logic [POS_W-1:0] microstep_position_o;
    logic [RESP_W-1:0] driver_status_word_o, frame_word;
    logic chopper_suspend_a_o, chopper_suspend_b_o, bridge_off_o, stall_test_output_o;
    // Expected flag state kept by the bench.
    logic open_load_coil_a = 1'b0, open_load_coil_b = 1'b0, ground_short_coil_a = 1'b0, ground_short_coil_b = 1'b0;
    // Clock enable, dropped once to prove that a step pulse leaves the position unchanged.
    logic clk_en = 1'b1;
    int n_mismatch = 0, tests_run = 0, cycles = 0;

    sdr_status_top i_sdr_status_top (.mclk_i(mclk_i), .reset_n_i(reset_n_i), .clk_en_i(clk_en),
        .step_i(step_i), .dir_i(dir_i), .step_size_i(step_size_i),
        .double_edge_select_i(double_edge_select_i), .read_select_i(read_select_i),
        .driver_enable_n_i(driver_enable_n_i), .off_time_zero_i(off_time_zero_i),
        .load_value_i(load_value_i), .current_scale_value_i(current_scale_value_i),
        .chopper_event_a_i(chopper_event_a_i), .chopper_event_b_i(chopper_event_b_i),
        .current_above_a_i(current_above_a_i), .current_above_b_i(current_above_b_i),
        .polarity_chg_a_i(polarity_chg_a_i), .polarity_chg_b_i(polarity_chg_b_i),
        .short_det_a_i(short_det_a_i), .short_det_b_i(short_det_b_i),
        .overtemp_warning_i(overtemp_warning_i), .overtemp_shutdown_i(overtemp_shutdown_i),
        .stall_flag_i(stall_flag_i), .frame_start_i(frame_start_i), .shift_i(shift_i),
        .resp_bit_o(resp_bit_o), .microstep_position_o(microstep_position_o),
        .driver_status_word_o(driver_status_word_o), .chopper_suspend_a_o(chopper_suspend_a_o),
        .chopper_suspend_b_o(chopper_suspend_b_o), .bridge_off_o(bridge_off_o),
        .stall_test_output_o(stall_test_output_o));

    sdr_ctl_model i_sdr_ctl_model (.mclk_i(mclk_i), .reset_n_i(reset_n_i),
        .frame_go_i(frame_go), .resp_bit_i(resp_bit_o), .frame_start_o(frame_start_i),
        .shift_o(shift_i), .frame_word_o(frame_word), .frame_done_o(frame_done));

    // ----------------------------------------------------------------
    // Tasks
    // ----------------------------------------------------------------
    // Wait for edges, then move just past the edge to drive safely.
    task automatic tick(input int n);
        repeat (n) @(posedge mclk_i);
        #1;
    endtask : tick

    // Compare with four-state equality so an unknown matches only the same unknown.
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // One-cycle strobe followed by a quiet cycle.
    task automatic pulse(ref logic s);
        s = 1'b1;
        tick(1);
        s = 0;
        tick(1);
    endtask : pulse

    // Hold a step level for four edges: sync, edge detect and count land.
    task automatic step_to(input logic lvl);
        step_i = lvl;
        tick(4);
    endtask : step_to

    // Run one serial frame and compare serial and captured words.
    task automatic frame(input logic [1:0] sel, input logic [POS_W-1:0] val);
        logic [RESP_W-1:0] exp_w;
        logic [RESP_W-1:0] keep;
        int k;
        exp_w = {val, 2'h0, 1'b0, open_load_coil_b, open_load_coil_a, ground_short_coil_b, ground_short_coil_a, overtemp_warning_i,
                 overtemp_shutdown_i, stall_flag_i};
        keep = 20'hFFCFF;
        read_select_i = sel;
        frame_go = 1'b1;
        tick(1);
        frame_go = 1'b0;
        k = 0;
        while (frame_done !== 1'b1 && k < 40) begin
            tick(1);
            k++;
        end
        check("frame done", frame_done, 1'b1);
        check("serial word", frame_word & keep, exp_w & keep);
        check("status word", driver_status_word_o & keep, exp_w & keep);
    endtask : frame

    // Print the verdict and stop.
    task automatic close_out();
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : close_out

    // ----------------------------------------------------------------
    // Clock, timeout and test sequence
    // ----------------------------------------------------------------
    initial begin
        forever #5 mclk_i = ~mclk_i;
    end

    // A hang counts as a mismatch and ends the run.
    always @(posedge mclk_i) begin
        cycles++;
        if (cycles == 5000) begin
            n_mismatch++;
            close_out();
        end
    end

    initial begin
        tick(16);
        reset_n_i = 1'b1;
        check("position", microstep_position_o, POS_RESET);
        for (int i = 0; i < 3; i++) begin
            step_to(1'b1);
            step_to(1'b0);
        end
        check("position", microstep_position_o, 10'h030);
        double_edge_select_i = 1'b1;
        dir_i = 1'b1;
        step_to(1'b1);
        step_to(1'b0);
        check("position", microstep_position_o, 10'h010);
        double_edge_select_i = 1'b0;
        step_to(1'b1);
        step_to(1'b0);
        step_i = 1'b1;
        tick(1);
        check("position", microstep_position_o, 10'h000);
        tick(3);
        check("position", microstep_position_o, 10'h3F0);
        // With the clock enable low a full step pulse must leave no trace.
        clk_en = 1'b0;
        step_to(1'b0);
        step_to(1'b1);
        clk_en = 1'b1;
        tick(4);
        check("position", microstep_position_o, 10'h3F0);
        frame(SEL_POSITION, 10'h3F0);
        check("polarity", driver_status_word_o[19], 1'b1);
        // Encoding three is never programmed.
        for (int s = 1; s < 3; s++) begin
            overtemp_warning_i = (s == 1);
            overtemp_shutdown_i = (s == 2);
            stall_flag_i = (s == 1);
            tick(1);
            check("stall test", stall_test_output_o, stall_flag_i);
            frame(s[1:0], (s == 1) ? 10'h2A5 : 10'h2B3);
        end
        // Open load: chopper activity keeps coil B clear, a bare period sets it.
        pulse(chopper_event_b_i);
        pulse(polarity_chg_b_i);
        pulse(polarity_chg_b_i);
        pulse(polarity_chg_a_i);
        open_load_coil_b = 1'b1;
        open_load_coil_a = 1'b1;
        frame(SEL_POSITION, 10'h3F0);
        check("bridge off", bridge_off_o, 1'b0);
        pulse(current_above_a_i);
        open_load_coil_a = 1'b0;
        frame(SEL_POSITION, 10'h3F0);
        // Short on coil A: count 1, 2, down to 1, then 2 and 3.
        short_det_a_i = 1'b1;
        #1;
        check("suspend a", chopper_suspend_a_o, 1'b1);
        tick(1);
        short_det_a_i = 1'b0;
        check("suspend a", chopper_suspend_a_o, 1'b0);
        tick(1);
        pulse(short_det_a_i);
        pulse(polarity_chg_a_i);
        open_load_coil_a = 1'b1;
        pulse(short_det_a_i);
        check("bridge off", bridge_off_o, 1'b0);
        pulse(short_det_a_i);
        check("bridge off", bridge_off_o, 1'b1);
        ground_short_coil_a = 1'b1;
        frame(SEL_POSITION, 10'h3F0);
        pulse(driver_enable_n_i);
        ground_short_coil_a = 1'b0;
        check("bridge off", bridge_off_o, 1'b0);
        // Short on coil B, cleared through a zero off time.
        short_det_b_i = 1'b1;
        #1;
        check("suspend b", chopper_suspend_b_o, 1'b1);
        tick(1);
        short_det_b_i = 1'b0;
        check("suspend b", chopper_suspend_b_o, 1'b0);
        tick(1);
        repeat (2) pulse(short_det_b_i);
        ground_short_coil_b = 1'b1;
        frame(SEL_POSITION, 10'h3F0);
        pulse(off_time_zero_i);
        ground_short_coil_b = 1'b0;
        check("bridge off", bridge_off_o, 1'b0);
        frame(SEL_POSITION, 10'h3F0);
        close_out();
    end
endmodule : sdr_status_top_bench
